//--- core/gcs_fifo.sv
module gcs_fifo
  import gcs_pkg::*;
#(
  parameter int W     = WORD_W,
  parameter int DEPTH = FIFO_DEPTH
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Fill side
  gcs_stream_if.snk  wr,
  // Drain side
  gcs_stream_if.src  rd
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0]   cnt;
  } gcs_fifo_st_t;

  gcs_fifo_st_t      st;
  gcs_fifo_st_t      next_st;
  logic [W-1:0]      mem [DEPTH];
  logic              push;
  logic              pop;

  // Honest full and empty drive both handshakes
  assign wr.ready = (st.cnt != (AW+1)'(DEPTH));
  assign rd.valid = (st.cnt != '0);
  assign rd.data  = mem[st.rp];
  assign push     = wr.valid && wr.ready;
  assign pop      = rd.valid && rd.ready;

  // Pointer and count update
  always_comb begin
    next_st = st;
    if (push) begin
      next_st.wp = (st.wp == AW'(DEPTH-1)) ? '0 : st.wp + 1'b1;
    end
    if (pop) begin
      next_st.rp = (st.rp == AW'(DEPTH-1)) ? '0 : st.rp + 1'b1;
    end
    next_st.cnt = st.cnt + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // Storage has no reset; only words written are ever read
  always_ff @(posedge sys_clk) begin
    if (push) begin
      mem[st.wp] <= wr.data;
    end
  end

  fifo_bound_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    st.cnt <= (AW+1)'(DEPTH))
    else $error("fifo count above depth");
endmodule

//--- core/gcs_port.sv
// Notes on behaviour
// - Tx transfer completes when ready, latency zero
// - Rx data held unchanged while valid low
// - Rx valid high with each new word
// - Last rx word marked, empty count given
module gcs_port
  import gcs_pkg::*;
(
  // Clock and reset
  input  wire logic               SYS_CLK,
  input  wire logic               RST_N,
  // Transmit client side
  input  wire logic               TX_VALID,
  input  wire logic               TX_SOP,
  input  wire logic               TX_EOP,
  input  wire logic [EMPTY_W-1:0] TX_EMPTY,
  input  wire logic [DATA_W-1:0]  TX_DATA,
  output wire logic               TX_READY,
  output wire logic               TX_PROTO_ERR,
  // Transmit toward the MAC core
  output wire logic               CORE_TX_VALID,
  output wire logic [WORD_W-1:0]  CORE_TX_WORD,
  input  wire logic               CORE_TX_READY,
  // Receive from the MAC core
  input  wire logic               CORE_RX_VALID,
  input  wire logic [WORD_W-1:0]  CORE_RX_WORD,
  output wire logic               CORE_RX_READY,
  // Receive client side
  output wire logic               RX_VALID,
  output wire logic               RX_SOP,
  output wire logic               RX_EOP,
  output wire logic [EMPTY_W-1:0] RX_EMPTY,
  output wire logic [DATA_W-1:0]  RX_DATA
);
  typedef struct packed {
    logic               in_pkt;
    logic               proto_err;
    logic               rx_valid;
    logic               rx_sop;
    logic               rx_eop;
    logic [EMPTY_W-1:0] rx_empty;
    logic [DATA_W-1:0]  rx_data;
  } gcs_port_st_t;

  gcs_port_st_t st;
  gcs_port_st_t next_st;
  logic         tx_take;
  logic [EMPTY_W-1:0] tx_empty_q;

  gcs_stream_if #(.W(WORD_W)) tx_in  ();
  gcs_stream_if #(.W(WORD_W)) tx_out ();

  // All checks below share one clock and stay quiet in reset
  default clocking gcs_cb @(posedge SYS_CLK);
  endclocking
  default disable iff (!RST_N);

  // Empty field only carried when it means something
  function automatic logic [EMPTY_W-1:0] gate_empty(
    input logic eop, input logic vld, input logic [EMPTY_W-1:0] e);
    gate_empty = (eop && vld) ? e : EMPTY_RST;
  endfunction

  // Transmit enters the buffer; ready straight from its free space
  assign tx_empty_q     = gate_empty(TX_EOP, TX_VALID, TX_EMPTY);
  assign tx_in.valid    = TX_VALID;
  assign tx_in.data     = {TX_SOP, TX_EOP, tx_empty_q, TX_DATA};
  assign TX_READY       = tx_in.ready;
  assign tx_take        = TX_VALID && tx_in.ready;
  assign CORE_TX_VALID  = tx_out.valid;
  assign CORE_TX_WORD   = tx_out.data;
  assign tx_out.ready   = CORE_TX_READY;
  assign TX_PROTO_ERR   = st.proto_err;

  gcs_fifo #(.W(WORD_W), .DEPTH(FIFO_DEPTH)) u_tx_fifo (
    .sys_clk (SYS_CLK),
    .rst_n   (RST_N),
    .wr      (tx_in),
    .rd      (tx_out)
  );

  // Receive output stage: one-word register, never stalls the core
  assign CORE_RX_READY = 1'b1;
  assign RX_VALID      = st.rx_valid;
  assign RX_SOP        = st.rx_sop;
  assign RX_EOP        = st.rx_eop;
  assign RX_EMPTY      = st.rx_empty;
  assign RX_DATA       = st.rx_data;

  always_comb begin
    next_st = st;
    // Packet tracking; errors are sticky to flag misbehaving clients
    if (tx_take) begin
      if (TX_SOP && st.in_pkt) begin
        next_st.proto_err = 1'b1;
      end
      if (!TX_SOP && !st.in_pkt) begin
        next_st.proto_err = 1'b1;
      end
      next_st.in_pkt = !TX_EOP;
    end else if (st.in_pkt && !TX_VALID) begin
      next_st.proto_err = 1'b1;
    end
    // New word only on core valid; data otherwise held
    next_st.rx_valid = CORE_RX_VALID;
    if (CORE_RX_VALID) begin
      next_st.rx_sop   = CORE_RX_WORD[WORD_W-1];
      next_st.rx_eop   = CORE_RX_WORD[WORD_W-2];
      next_st.rx_empty = gate_empty(CORE_RX_WORD[WORD_W-2], 1'b1,
                           CORE_RX_WORD[DATA_W +: EMPTY_W]);
      next_st.rx_data  = CORE_RX_WORD[DATA_W-1:0];
    end else begin
      next_st.rx_sop = 1'b0;
      next_st.rx_eop = 1'b0;
    end
  end

  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      st <= '{in_pkt: 1'b0, proto_err: 1'b0, rx_valid: 1'b0,
              rx_sop: 1'b0, rx_eop: 1'b0, rx_empty: EMPTY_RST,
              rx_data: DATA_RST};
    end else begin
      st <= next_st;
    end
  end

  // Data held while no new word; client may sample late
  rx_hold_a: assert property (
    !st.rx_valid |-> $stable(RX_DATA))
    else $error("rx data moved while valid low");

  // Every core word shows one cycle later, flagged valid
  rx_new_a: assert property (
    CORE_RX_VALID |=> RX_VALID &&
      RX_DATA == $past(CORE_RX_WORD[DATA_W-1:0]))
    else $error("rx word not presented with valid");

  // Start marker travels with its word
  rx_sop_a: assert property (
    CORE_RX_VALID |=> RX_SOP == $past(CORE_RX_WORD[WORD_W-1]))
    else $error("rx start marker lost");

  // No core word means no valid and no markers
  rx_idle_a: assert property (
    !CORE_RX_VALID |=> !RX_VALID && !RX_SOP && !RX_EOP)
    else $error("rx valid without core word");

  // Receive path never pushes back on the core
  rx_ready_a: assert property (
    CORE_RX_READY)
    else $error("rx core stalled");

  // End marker and empty count reach the client together
  rx_eop_a: assert property (
    CORE_RX_VALID && CORE_RX_WORD[WORD_W-2] |=> RX_EOP &&
      RX_EMPTY == $past(CORE_RX_WORD[DATA_W +: EMPTY_W]))
    else $error("rx end or empty lost");

  // Middle words never carry the end marker
  rx_mid_a: assert property (
    CORE_RX_VALID && !CORE_RX_WORD[WORD_W-2] |=> !RX_EOP)
    else $error("rx end set on middle word");

  // Empty forced to zero off the last word, a clean value
  rx_empty_a: assert property (
    CORE_RX_VALID && !CORE_RX_WORD[WORD_W-2] |=> RX_EMPTY == '0)
    else $error("rx empty set off end");

  // Empty count only moves with a new word
  rx_keep_a: assert property (
    !CORE_RX_VALID |=> $stable(RX_EMPTY))
    else $error("rx empty moved while idle");

  // Accepted word always lands in the buffer
  tx_ready_a: assert property (
    TX_VALID && TX_READY |=> CORE_TX_VALID)
    else $error("accepted tx word not buffered");

  // Ready low only when the buffer holds words
  tx_full_a: assert property (
    !TX_READY |-> CORE_TX_VALID)
    else $error("tx ready low with empty buffer");

  // Into an empty buffer the word is at the head next cycle
  tx_first_a: assert property (
    TX_VALID && TX_READY && !CORE_TX_VALID |=>
      CORE_TX_WORD[DATA_W-1:0] == $past(TX_DATA) &&
      CORE_TX_WORD[WORD_W-1 -: 2] == $past({TX_SOP, TX_EOP}))
    else $error("tx word corrupted in buffer");

  // Middle words enter the buffer with a zero empty field
  tx_empty_a: assert property (
    TX_VALID && TX_READY && !TX_EOP && !CORE_TX_VALID |=>
      CORE_TX_WORD[DATA_W +: EMPTY_W] == '0)
    else $error("tx empty kept off end");

  // Head word stays put while the core stalls
  tx_hold_a: assert property (
    CORE_TX_VALID && !CORE_TX_READY |=>
      CORE_TX_VALID && $stable(CORE_TX_WORD))
    else $error("tx head moved during stall");

  // Misuse flag is sticky so software cannot miss it
  err_sticky_a: assert property (
    TX_PROTO_ERR |=> TX_PROTO_ERR)
    else $error("protocol error flag cleared");

  // Valid dropped inside a packet is misuse
  err_drop_a: assert property (
    st.in_pkt && !TX_VALID |=> TX_PROTO_ERR)
    else $error("valid gap in packet not flagged");

  // Start marker inside an open packet is misuse
  err_sop_a: assert property (
    tx_take && TX_SOP && st.in_pkt |=> TX_PROTO_ERR)
    else $error("nested start not flagged");

  // A packet must open with a start marker
  err_nosop_a: assert property (
    tx_take && !TX_SOP && !st.in_pkt |=> TX_PROTO_ERR)
    else $error("missing start not flagged");

  // Flag rises only from a client word or an open packet
  err_cause_a: assert property (
    $rose(TX_PROTO_ERR) |-> $past(st.in_pkt || tx_take))
    else $error("protocol error without cause");

  // End marker closes the packet
  pkt_end_a: assert property (
    tx_take && TX_EOP |=> !st.in_pkt)
    else $error("packet left open after end");

  // A word without end marker keeps the packet open
  pkt_open_a: assert property (
    tx_take && !TX_EOP |=> st.in_pkt)
    else $error("packet closed early");
endmodule

//--- shared/gcs_pkg.sv
package gcs_pkg;
  localparam int DATA_W     = 256;
  localparam int EMPTY_W    = 5;
  localparam int FIFO_DEPTH = 4;
  // Word layout inside the buffer: {sop, eop, empty, data}
  localparam int WORD_W     = DATA_W + EMPTY_W + 2;
  localparam logic [EMPTY_W-1:0] EMPTY_RST = 5'h00;
  localparam logic [DATA_W-1:0]  DATA_RST  = {DATA_W{1'b0}};
endpackage

//--- shared/gcs_stream_if.sv
interface gcs_stream_if #(parameter int W = 8);
  logic         valid;
  logic         ready;
  logic [W-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface

//--- testbench/gcs_core_model.sv
module gcs_core_model
  import gcs_pkg::*;
(
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              rst_n,
  // Drain control and buffer head
  input  wire logic              stall,
  input  wire logic              tx_valid,
  input  wire logic [WORD_W-1:0] tx_word,
  output wire logic              tx_ready,
  // Looped-back words
  output      logic              rx_valid,
  output      logic [WORD_W-1:0] rx_word
);
  timeunit 1ns;
  timeprecision 1ps;
  assign tx_ready = !stall;
  // Idle bus shows the inverse, so stale data never looks fresh
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_valid <= 1'b0;
      rx_word  <= '0;
    end else begin
      rx_valid <= tx_valid && tx_ready;
      rx_word  <= (tx_valid && tx_ready) ? tx_word : ~rx_word;
    end
  end
endmodule

//--- testbench/tb_top.sv
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin fails++; \
  $display("mismatch t=%0t got=%0h exp=%0h", $time, a, b); end end
module tb_top
  import gcs_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic SYS_CLK, RST_N, TX_VALID, TX_SOP, TX_EOP, TX_READY, TX_PROTO_ERR;
  logic CORE_TX_VALID, CORE_TX_READY, CORE_RX_VALID, CORE_RX_READY;
  logic RX_VALID, RX_SOP, RX_EOP, stall, chk_on, saw_full;
  logic [EMPTY_W-1:0] TX_EMPTY, RX_EMPTY;
  logic [DATA_W-1:0]  TX_DATA, RX_DATA, last_d;
  logic [WORD_W-1:0]  CORE_TX_WORD, CORE_RX_WORD;
  logic [WORD_W-1:0]  exp_q[$];
  logic [31:0]        seed = 32'h0000543F;
  int fails, total_checks, cyc, p, i, n;
  gcs_port DUT (
    .SYS_CLK       (SYS_CLK),
    .RST_N         (RST_N),
    .TX_VALID      (TX_VALID),
    .TX_SOP        (TX_SOP),
    .TX_EOP        (TX_EOP),
    .TX_EMPTY      (TX_EMPTY),
    .TX_DATA       (TX_DATA),
    .TX_READY      (TX_READY),
    .TX_PROTO_ERR  (TX_PROTO_ERR),
    .CORE_TX_VALID (CORE_TX_VALID),
    .CORE_TX_WORD  (CORE_TX_WORD),
    .CORE_TX_READY (CORE_TX_READY),
    .CORE_RX_VALID (CORE_RX_VALID),
    .CORE_RX_WORD  (CORE_RX_WORD),
    .CORE_RX_READY (CORE_RX_READY),
    .RX_VALID      (RX_VALID),
    .RX_SOP        (RX_SOP),
    .RX_EOP        (RX_EOP),
    .RX_EMPTY      (RX_EMPTY),
    .RX_DATA       (RX_DATA)
  );
  gcs_core_model core (.clk(SYS_CLK), .rst_n(RST_N), .stall(stall),
    .tx_valid(CORE_TX_VALID), .tx_word(CORE_TX_WORD),
    .tx_ready(CORE_TX_READY), .rx_valid(CORE_RX_VALID),
    .rx_word(CORE_RX_WORD));
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic final_report();
    if (fails == 0 && total_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // One client beat, held until taken; off-end empty must read back 0
  task automatic send(input logic s, input logic e, input logic [4:0] em);
    logic [DATA_W-1:0] d;
    d = {8{rnd()}};
    {TX_VALID, TX_SOP, TX_EOP, TX_EMPTY, TX_DATA} <= {1'b1, s, e, em, d};
    @(negedge SYS_CLK);
    while (TX_READY !== 1'b1) @(negedge SYS_CLK);
    exp_q.push_back({s, e, e ? em : 5'h00, d});
    @(posedge SYS_CLK);
  endtask
  initial begin
    SYS_CLK = 0;
    forever #10 SYS_CLK = ~SYS_CLK;
  end
  // Bursts of 16 stalled cycles fill the 4-word buffer
  always @(posedge SYS_CLK) begin
    cyc <= cyc + 1;
    stall <= (cyc[5:4] == 2'h3) | rnd() % 4 == 0;
    if (cyc == 6000) begin
      fails++;
      final_report();
    end
  end
  // Receive monitor, sampled mid-cycle where outputs are settled
  always @(negedge SYS_CLK) begin
    if (TX_READY === 1'b0) saw_full = 1;
    if (!RST_N) last_d = DATA_RST;
    else if (chk_on && RX_VALID === 1'b1) begin
      `CHK({RX_SOP, RX_EOP, RX_EMPTY, RX_DATA}, exp_q.pop_front())
      last_d = RX_DATA;
    end else if (chk_on) `CHK(RX_DATA, last_d)
  end
  initial begin
    {RST_N, TX_VALID, TX_SOP, TX_EOP, TX_EMPTY, TX_DATA} = '0;
    {cyc, stall, chk_on, saw_full} = '0;
    repeat (10) @(posedge SYS_CLK);
    `CHK({TX_READY, CORE_TX_VALID, RX_VALID, TX_PROTO_ERR, CORE_RX_READY}, 5'h11)
    RST_N <= 1;
    chk_on <= 1;
    for (p = 0; p < 40; p++) begin
      n = rnd() % 6 + 1;
      for (i = 0; i < n; i++) send(i == 0, i == n - 1, 5'(rnd()));
    end
    TX_VALID <= 0;
    for (i = 0; i < 200 && exp_q.size() > 0; i++) @(posedge SYS_CLK);
    `CHK(exp_q.size(), 0)
    `CHK(saw_full, 1'b1)
    `CHK(TX_PROTO_ERR, 1'b0)
    // Start marker inside an open packet must flag misuse
    chk_on <= 0;
    send(1, 0, 0);
    send(1, 1, 0);
    TX_VALID <= 0;
    repeat (3) @(posedge SYS_CLK);
    `CHK(TX_PROTO_ERR, 1'b1)
    RST_N <= 0;
    @(negedge SYS_CLK);
    `CHK({TX_READY, CORE_TX_VALID, RX_VALID, TX_PROTO_ERR, CORE_RX_READY}, 5'h11)
    final_report();
  end
endmodule
